//--- hw/mtr_pkg.sv
// Contract
// R1: Positive and negative sequence magnitudes from the phase currents feed the model.
// R2: Heating current is sqrt of I1 squared plus weight times I2 squared.
// R3: Above 1.5 rated current, I2 is clamped there and weight becomes 500 %.
// R4: Heating time constant while rotating; cooling constant is a percentage at standstill.
// R5: Overtemperature rate equals heating term minus overtemperature, over the time constant.
// R6: Reported temperature is overtemperature plus ambient temperature.
// R7: Sensor select picks measured ambient, otherwise the ambient setting.
// R8: Alarm, trip and unlock outputs assert when temperature exceeds their thresholds.
// R9: Model scales by rated load current, rated temperature and base temperature.
// R10: On energization the level is preloaded with the start-up percentage.
// R11: Heavy-start input halves the calculated heat.
// R12: Level update: old times one minus step over T, plus step over T times ratio.
// R13: Level is overtemperature as a fraction of the rated overtemperature.
// R14: Locked mode holds trip until temperature falls below the unlock threshold.
// R15: Update runs at a fixed calculation period used as the step size.
// R16: With operation off, alarm, trip and unlock stay deasserted.
package mtr_pkg;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned CALC_STEP_MS = 20;
  localparam int unsigned NS_PER_MS = 1_000_000;
  localparam int unsigned CALC_STEP_CYCLES = (CALC_STEP_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int unsigned MS_PER_MIN = 60_000;

  // Scaling: current code equal to the nominal current
  localparam int unsigned CUR_RATED = 1000;
  localparam logic [15:0] NEG_LIMIT = 16'((CUR_RATED * 3) / 2);
  localparam logic [15:0] NEG_LIMIT_WEIGHT = 16'h01F4;
  localparam int unsigned PCT_FULL = 100;
  localparam int unsigned LEVEL_FRAC = 16;
  localparam int unsigned ALPHA_FRAC = 24;
  localparam int unsigned DIV_W = 56;
  localparam int unsigned SQRT_W = 40;

  // Register byte offsets
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_NEG_WEIGHT = 8'h04;
  localparam logic [7:0] OFF_HEAT_TC = 8'h08;
  localparam logic [7:0] OFF_COOL_PCT = 8'h0C;
  localparam logic [7:0] OFF_AMBIENT = 8'h10;
  localparam logic [7:0] OFF_ALARM = 8'h14;
  localparam logic [7:0] OFF_TRIP = 8'h18;
  localparam logic [7:0] OFF_UNLOCK = 8'h1C;
  localparam logic [7:0] OFF_RATED_CUR = 8'h20;
  localparam logic [7:0] OFF_RATED_TEMP = 8'h24;
  localparam logic [7:0] OFF_BASE_TEMP = 8'h28;
  localparam logic [7:0] OFF_STARTUP = 8'h2C;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  localparam logic [7:0] OFF_LEVEL = 8'h34;
  localparam logic [7:0] OFF_HEAT_CUR = 8'h38;
  localparam logic [7:0] OFF_INT_STAT = 8'h3C;
  localparam logic [7:0] OFF_INT_MASK = 8'h40;

  // Field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_SENSOR_BIT = 2;
  localparam int unsigned CTRL_PRELOAD_BIT = 3;
  localparam int unsigned STAT_TEMP_LSB = 16;
  localparam int unsigned NUM_EVENTS = 3;

  typedef enum logic [1:0] {
    MTR_OFF = 2'h0,
    MTR_PULSED = 2'h1,
    MTR_LOCKED = 2'h2
  } mtr_mode_t;

  // Status outputs, also the low bits of STATUS
  typedef struct packed {
    logic unlock;
    logic trip;
    logic alarm;
  } mtr_flags_t;

  // Sequence magnitudes from the upstream calculation
  typedef struct packed {
    logic [15:0] pos_mag;
    logic [15:0] neg_mag;
  } mtr_seq_t;

  typedef struct packed {
    mtr_mode_t mode;
    logic sensor_sel;
    logic [15:0] neg_seq_weight;
    logic [15:0] heating_time_const;
    logic [15:0] cooling_ratio_pct;
    logic [7:0] ambient_setting;
    logic [7:0] alarm_threshold;
    logic [7:0] trip_threshold;
    logic [7:0] unlock_threshold;
    logic [7:0] rated_load_current;
    logic [7:0] rated_temperature;
    logic [7:0] base_temperature;
    logic [7:0] startup_term;
  } mtr_cfg_t;

  // Reset values of the settings
  localparam mtr_cfg_t CFG_RESET = '{
    mode: MTR_PULSED, sensor_sel: 1'b0, neg_seq_weight: 16'h0064,
    heating_time_const: 16'h000A, cooling_ratio_pct: 16'h0064,
    ambient_setting: 8'h19, alarm_threshold: 8'h50, trip_threshold: 8'h64,
    unlock_threshold: 8'h3C, rated_load_current: 8'h64, rated_temperature: 8'h64,
    base_temperature: 8'h19, startup_term: 8'h00};

endpackage

//--- hw/mtr_div.sv
`timescale 1ns/1ps
`default_nettype none
// Restoring unsigned divider, one quotient bit per clock
module mtr_div #(
  parameter int unsigned W = 56
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic [W-1:0] num,
  input wire logic [W-1:0] den,
  output logic done,
  output logic [W-1:0] quo
);
  typedef struct packed {
    logic busy;
    logic fin;
    logic [W:0] rem;
    logic [W-1:0] q;
    logic [W-1:0] d;
    logic [$clog2(W+1)-1:0] cnt;
  } mtr_div_state_t;

  mtr_div_state_t s, n;
  logic [W:0] shifted;

  // Shift one numerator bit in, subtract when it fits
  always_comb begin
    n = s;
    n.fin = 1'b0;
    shifted = {s.rem[W-1:0], s.q[W-1]};
    if (start) begin
      n.busy = 1'b1;
      n.rem = '0;
      n.q = num;
      n.d = den;
      n.cnt = '0;
    end else if (s.busy) begin
      n.q = {s.q[W-2:0], 1'b0};
      if (shifted >= {1'b0, s.d}) begin
        n.rem = shifted - {1'b0, s.d};
        n.q[0] = 1'b1;
      end else begin
        n.rem = shifted;
      end
      n.cnt = s.cnt + 1'b1;
      if (s.cnt == ($clog2(W+1))'(W - 1)) begin
        n.busy = 1'b0;
        n.fin = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign done = s.fin;
  assign quo = s.q;
endmodule
`default_nettype wire

//--- hw/mtr_isqrt.sv
`timescale 1ns/1ps
`default_nettype none
// Digit-by-digit integer square root, two radicand bits per clock
module mtr_isqrt #(
  parameter int unsigned W = 40
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic [W-1:0] radicand,
  output logic done,
  output logic [W/2-1:0] root
);
  typedef struct packed {
    logic busy;
    logic fin;
    logic [W-1:0] rad;
    logic [W/2+1:0] rem;
    logic [W/2-1:0] r;
    logic [$clog2(W)-1:0] cnt;
  } mtr_sqrt_state_t;

  mtr_sqrt_state_t s, n;
  logic [W/2+1:0] rem_t;
  logic [W/2+1:0] trial;

  always_comb begin
    n = s;
    n.fin = 1'b0;
    rem_t = {s.rem[W/2-1:0], s.rad[W-1:W-2]};
    trial = {s.r, 2'h1};
    if (start) begin
      n.busy = 1'b1;
      n.rad = radicand;
      n.rem = '0;
      n.r = '0;
      n.cnt = '0;
    end else if (s.busy) begin
      n.rad = {s.rad[W-3:0], 2'h0};
      // Keep the root bit only when the trial fits in the remainder
      if (rem_t >= trial) begin
        n.rem = rem_t - trial;
        n.r = {s.r[W/2-2:0], 1'b1};
      end else begin
        n.rem = rem_t;
        n.r = {s.r[W/2-2:0], 1'b0};
      end
      n.cnt = s.cnt + 1'b1;
      if (s.cnt == ($clog2(W))'(W/2 - 1)) begin
        n.busy = 1'b0;
        n.fin = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign done = s.fin;
  assign root = s.r;
endmodule
`default_nettype wire

//--- hw/mtr_thermal.sv
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Motor thermal replica with AHB-Lite register access
module mtr_thermal
  import mtr_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = mtr_pkg::CALC_STEP_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire mtr_pkg::mtr_seq_t seq_in,
  input wire logic signed [15:0] ambient_meas,
  input wire logic motor_running,
  input wire logic heavy_start,
  output mtr_pkg::mtr_flags_t status,
  output logic signed [15:0] temperature,
  output logic irq
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DIV_HEAT = 3'h1,
    ST_DIV_ALPHA = 3'h3,
    ST_UPDATE = 3'h2,
    ST_PRELOAD = 3'h6
  } mtr_fsm_t;

  typedef struct packed {
    mtr_cfg_t cfg;
    logic [NUM_EVENTS-1:0] int_stat;
    logic [NUM_EVENTS-1:0] int_mask;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] rdata;
    logic [31:0] step_cnt;
    logic step_due;
    logic preload_req;
    mtr_fsm_t st;
    logic running;
    logic [31:0] level;
    logic [31:0] heat_ratio;
    logic [31:0] alpha;
    logic [19:0] heat_cur;
    logic signed [15:0] temp;
    mtr_flags_t flags;
  } mtr_state_t;

  localparam logic [31:0] LEVEL_ONE = 32'h0001_0000;
  localparam logic [31:0] ALPHA_ONE = 32'h0100_0000;
  localparam logic [31:0] LEVEL_MAX = 32'hFFFF_FFFF;
  localparam logic signed [17:0] TEMP_MAX = 18'sh07FFF;
  localparam logic signed [17:0] TEMP_MIN = -18'sh08000;

  mtr_state_t s, n;

  // Shared arithmetic engines, driven from the sequencer
  logic div_start;
  logic [DIV_W-1:0] div_num;
  logic [DIV_W-1:0] div_den;
  logic div_done;
  logic [DIV_W-1:0] div_quo;
  logic sqrt_start;
  logic [SQRT_W-1:0] heat_sq;
  logic sqrt_done;
  logic [SQRT_W/2-1:0] sqrt_root;

  // Combinational helpers
  logic [15:0] i2_used;
  logic [15:0] weight_used;
  logic [31:0] iref;
  logic [31:0] tc_ms;
  logic signed [32:0] diff;
  logic signed [65:0] prod;
  logic signed [33:0] lvl_sum;
  logic [31:0] level_new;
  logic [7:0] rise;
  logic [39:0] ovt_full;
  logic signed [17:0] ovt;
  logic signed [17:0] temp_sum;
  logic signed [15:0] temp_new;
  logic signed [15:0] amb;
  mtr_flags_t flags_new;
  logic [NUM_EVENTS-1:0] ev_set;
  logic [NUM_EVENTS-1:0] ev_clr;

  // Percentage of a value, shared by several scalings
  function automatic logic [31:0] pct_of(input logic [31:0] x, input logic [15:0] pct);
    logic [47:0] p;
    p = 48'(x) * 48'(pct);
    return 32'(p / 48'(PCT_FULL));
  endfunction

  // Register read decode; unmapped offsets read zero
  function automatic logic [31:0] rd_word(input logic [ADDR_W-1:0] a, input mtr_state_t q);
    logic [31:0] w;
    w = '0;
    case (a)
      OFF_CTRL: begin
        w[CTRL_MODE_LSB +: 2] = q.cfg.mode;
        w[CTRL_SENSOR_BIT] = q.cfg.sensor_sel;
      end
      OFF_NEG_WEIGHT: w[15:0] = q.cfg.neg_seq_weight;
      OFF_HEAT_TC: w[15:0] = q.cfg.heating_time_const;
      OFF_COOL_PCT: w[15:0] = q.cfg.cooling_ratio_pct;
      OFF_AMBIENT: w[7:0] = q.cfg.ambient_setting;
      OFF_ALARM: w[7:0] = q.cfg.alarm_threshold;
      OFF_TRIP: w[7:0] = q.cfg.trip_threshold;
      OFF_UNLOCK: w[7:0] = q.cfg.unlock_threshold;
      OFF_RATED_CUR: w[7:0] = q.cfg.rated_load_current;
      OFF_RATED_TEMP: w[7:0] = q.cfg.rated_temperature;
      OFF_BASE_TEMP: w[7:0] = q.cfg.base_temperature;
      OFF_STARTUP: w[7:0] = q.cfg.startup_term;
      OFF_STATUS: begin
        w[NUM_EVENTS-1:0] = q.flags;
        w[STAT_TEMP_LSB +: 16] = q.temp;
      end
      OFF_LEVEL: w = q.level;
      OFF_HEAT_CUR: w[19:0] = q.heat_cur;
      OFF_INT_STAT: w[NUM_EVENTS-1:0] = q.int_stat;
      OFF_INT_MASK: w[NUM_EVENTS-1:0] = q.int_mask;
      default: w = '0;
    endcase
    return w;
  endfunction

  // Heating term from sequence magnitudes, negative sequence limited
  always_comb begin
    if (seq_in.neg_mag > NEG_LIMIT) begin // R3
      i2_used = NEG_LIMIT;
      weight_used = NEG_LIMIT_WEIGHT;
    end else begin
      i2_used = seq_in.neg_mag; // R1
      weight_used = s.cfg.neg_seq_weight;
    end
    heat_sq = SQRT_W'(32'(seq_in.pos_mag) * 32'(seq_in.pos_mag))
      + SQRT_W'(pct_of(32'(i2_used) * 32'(i2_used), weight_used)); // R2
    iref = pct_of(32'(CUR_RATED), 16'(s.cfg.rated_load_current)); // R9
    // Cooling constant applies only at standstill; never let it reach zero
    tc_ms = 32'(s.cfg.heating_time_const) * 32'(MS_PER_MIN);
    if (!s.running) begin
      tc_ms = pct_of(tc_ms, s.cfg.cooling_ratio_pct); // R4
    end
    if (tc_ms == '0) begin
      tc_ms = 32'h1;
    end
  end

  // Level step, scaled temperature and threshold decisions
  always_comb begin
    diff = $signed({1'b0, s.heat_ratio}) - $signed({1'b0, s.level}); // R5
    prod = 66'(diff) * 66'($signed({1'b0, s.alpha}));
    lvl_sum = $signed({2'h0, s.level}) + prod[57:24]; // R12
    if (lvl_sum < 0) begin
      level_new = '0;
    end else if (lvl_sum[33:32] != 2'h0) begin
      level_new = LEVEL_MAX;
    end else begin
      level_new = lvl_sum[31:0];
    end
    // Rated overtemperature is rated minus base; a bad setting yields no heating
    if (s.cfg.rated_temperature > s.cfg.base_temperature) begin
      rise = s.cfg.rated_temperature - s.cfg.base_temperature; // R9
    end else begin
      rise = '0;
    end
    ovt_full = 40'(level_new) * 40'(rise); // R13
    if (ovt_full[39:LEVEL_FRAC] > 24'(TEMP_MAX)) begin
      ovt = TEMP_MAX;
    end else begin
      ovt = $signed(18'(ovt_full[39:LEVEL_FRAC]));
    end
    amb = s.cfg.sensor_sel ? ambient_meas : $signed({8'h00, s.cfg.ambient_setting}); // R7
    temp_sum = ovt + 18'(amb); // R6
    if (temp_sum > TEMP_MAX) begin
      temp_new = 16'(TEMP_MAX);
    end else if (temp_sum < TEMP_MIN) begin
      temp_new = 16'(TEMP_MIN);
    end else begin
      temp_new = temp_sum[15:0];
    end
    flags_new.alarm = temp_new > $signed({8'h00, s.cfg.alarm_threshold}); // R8
    flags_new.unlock = temp_new > $signed({8'h00, s.cfg.unlock_threshold}); // R8
    if (s.cfg.mode == MTR_LOCKED && s.flags.trip) begin
      flags_new.trip = temp_new >= $signed({8'h00, s.cfg.unlock_threshold}); // R14
    end else begin
      flags_new.trip = temp_new > $signed({8'h00, s.cfg.trip_threshold}); // R8
    end
  end

  // Bus, timer, sequencer and interrupt next state
  always_comb begin
    n = s;
    div_start = 1'b0;
    div_num = '0;
    div_den = '0;
    sqrt_start = 1'b0;
    ev_clr = '0;
    ev_set = '0;
    // Address phase: read data is registered for the data phase
    n.wr_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      if (hwrite) begin
        n.wr_pend = 1'b1;
        n.wr_addr = haddr[ADDR_W-1:0];
      end else begin
        n.rdata = rd_word(haddr[ADDR_W-1:0], s);
      end
    end
    // Data phase writes
    if (s.wr_pend) begin
      case (s.wr_addr)
        OFF_CTRL: begin
          n.cfg.mode = mtr_mode_t'(hwdata[CTRL_MODE_LSB +: 2]);
          n.cfg.sensor_sel = hwdata[CTRL_SENSOR_BIT];
          n.preload_req = s.preload_req | hwdata[CTRL_PRELOAD_BIT];
        end
        OFF_NEG_WEIGHT: n.cfg.neg_seq_weight = hwdata[15:0];
        OFF_HEAT_TC: n.cfg.heating_time_const = hwdata[15:0];
        OFF_COOL_PCT: n.cfg.cooling_ratio_pct = hwdata[15:0];
        OFF_AMBIENT: n.cfg.ambient_setting = hwdata[7:0];
        OFF_ALARM: n.cfg.alarm_threshold = hwdata[7:0];
        OFF_TRIP: n.cfg.trip_threshold = hwdata[7:0];
        OFF_UNLOCK: n.cfg.unlock_threshold = hwdata[7:0];
        OFF_RATED_CUR: n.cfg.rated_load_current = hwdata[7:0];
        OFF_RATED_TEMP: n.cfg.rated_temperature = hwdata[7:0];
        OFF_BASE_TEMP: n.cfg.base_temperature = hwdata[7:0];
        OFF_STARTUP: n.cfg.startup_term = hwdata[7:0];
        OFF_INT_STAT: ev_clr = hwdata[NUM_EVENTS-1:0];
        OFF_INT_MASK: n.int_mask = hwdata[NUM_EVENTS-1:0];
        default: n.int_mask = s.int_mask;
      endcase
    end
    // Fixed calculation period; a step that arrives while busy waits
    if (s.step_cnt == 32'(STEP_CYCLES - 1)) begin
      n.step_cnt = '0;
      n.step_due = 1'b1; // R15
    end else begin
      n.step_cnt = s.step_cnt + 32'h1;
    end
    case (s.st)
      ST_PRELOAD: begin
        n.level = pct_of(LEVEL_ONE, 16'(s.cfg.startup_term)); // R10
        n.preload_req = 1'b0;
        n.st = ST_IDLE;
      end
      ST_IDLE: begin
        if (s.preload_req) begin
          n.st = ST_PRELOAD;
        end else if (s.step_due) begin
          n.step_due = 1'b0;
          n.running = motor_running;
          div_start = 1'b1;
          div_num = DIV_W'(heat_sq) << LEVEL_FRAC;
          if (heavy_start) begin
            div_num = DIV_W'(heat_sq) << (LEVEL_FRAC - 1); // R11
          end
          div_den = DIV_W'(64'(iref) * 64'(iref));
          sqrt_start = 1'b1;
          n.st = ST_DIV_HEAT;
        end
      end
      ST_DIV_HEAT: begin
        if (div_done) begin
          n.heat_ratio = (div_quo > DIV_W'(LEVEL_MAX)) ? LEVEL_MAX : div_quo[31:0];
          div_start = 1'b1;
          div_num = DIV_W'(CALC_STEP_MS) << ALPHA_FRAC; // R15
          div_den = DIV_W'(tc_ms);
          n.st = ST_DIV_ALPHA;
        end
      end
      ST_DIV_ALPHA: begin
        if (div_done) begin
          n.alpha = (div_quo > DIV_W'(ALPHA_ONE)) ? ALPHA_ONE : div_quo[31:0];
          n.st = ST_UPDATE;
        end
      end
      ST_UPDATE: begin
        n.level = level_new; // R12
        n.temp = temp_new; // R6
        n.flags = flags_new; // R8
        n.st = ST_IDLE;
      end
      default: n.st = ST_IDLE;
    endcase
    if (sqrt_done) begin
      n.heat_cur = sqrt_root; // R2
    end
    // Operation off forces every decision output low
    if (s.cfg.mode != MTR_PULSED && s.cfg.mode != MTR_LOCKED) begin
      n.flags = '0; // R16
    end
    // Events: alarm rise, trip rise, trip release; a new event beats a clear
    ev_set[0] = n.flags.alarm & ~s.flags.alarm;
    ev_set[1] = n.flags.trip & ~s.flags.trip;
    ev_set[2] = ~n.flags.trip & s.flags.trip;
    n.int_stat = (s.int_stat & ~ev_clr) | ev_set;
  end

  // The sequencer starts in preload so energization sets the start-up level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.cfg <= CFG_RESET;
      s.st <= ST_PRELOAD; // R10
    end else begin
      s <= n;
    end
  end

  mtr_div #(
    .W(DIV_W)
  ) u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(div_start),
    .num(div_num),
    .den(div_den),
    .done(div_done),
    .quo(div_quo)
  );

  mtr_isqrt #(
    .W(SQRT_W)
  ) u_sqrt (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(sqrt_start),
    .radicand(heat_sq),
    .done(sqrt_done),
    .root(sqrt_root)
  );

  // Zero-wait slave; hsize is accepted as word only
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign status = s.flags;
  assign temperature = s.temp;
  assign irq = |(s.int_stat & s.int_mask);
endmodule
`default_nettype wire

//--- tb/mtr_thermal_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Bus answers and status flags against snooped settings
module mtr_thermal_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire mtr_pkg::mtr_flags_t status,
  input wire logic signed [15:0] temperature
);
  import mtr_pkg::*;
  logic wph, on, rd_take;
  logic [7:0] aph, alm, trp, unl;
  logic [1:0] mode;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Shadow settings from bus writes; no peeking inside
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wph <= 1'b0;
      aph <= 8'h00;
      mode <= 2'h1;
      alm <= CFG_RESET.alarm_threshold;
      trp <= CFG_RESET.trip_threshold;
      unl <= CFG_RESET.unlock_threshold;
    end else if (hready) begin
      wph <= hsel && htrans[1] && hwrite;
      aph <= haddr[7:0];
      if (wph && aph == OFF_CTRL) mode <= hwdata[1:0];
      if (wph && aph == OFF_ALARM) alm <= hwdata[7:0];
      if (wph && aph == OFF_TRIP) trp <= hwdata[7:0];
      if (wph && aph == OFF_UNLOCK) unl <= hwdata[7:0];
    end
  end
  // Mode 3 behaves as off
  assign on = (mode == 2'h1) || (mode == 2'h2);
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  ready_high_a: assert property (hreadyout == 1'b1) else $error("hreadyout low");
  resp_okay_a: assert property (hresp == 1'b0) else $error("hresp not OKAY");
  status_mirror_a: assert property (rd_take && haddr[7:0] == OFF_STATUS |=>
    hrdata == {$past(temperature), 13'h0000, $past(status)}) else $error("STATUS read mismatch");
  unmapped_zero_a: assert property (rd_take && haddr[7:0] > OFF_INT_MASK |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  alarm_level_a: assert property (on && $changed(temperature) |->
    status.alarm == (temperature > $signed({8'h00, alm}))) else $error("alarm flag wrong");
  unlock_level_a: assert property (on && $changed(temperature) |->
    status.unlock == (temperature > $signed({8'h00, unl}))) else $error("unlock flag wrong");
  trip_latch_a: assert property (on && $changed(temperature) |-> status.trip ==
    (temperature > $signed({8'h00, trp}) || mode == 2'h2 && $past(status.trip)
    && temperature >= $signed({8'h00, unl}))) else $error("trip flag wrong");
  off_quiet_a: assert property (!on [*2] |-> status == 3'h0) else $error("flags set while off");
endmodule
bind mtr_thermal mtr_thermal_chk chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hreadyout, .hresp, .hrdata, .status, .temperature);
`default_nettype wire

//--- tb/mtr_upstream.sv
`timescale 1ns/1ps
`default_nettype none
// Sequence front end and ambient probe
module mtr_upstream (
  input wire logic hclk,
  output mtr_pkg::mtr_seq_t seq_in,
  output logic signed [15:0] ambient_meas,
  output logic motor_running,
  output logic heavy_start
);
  import mtr_pkg::*;
  // Rest state: no current, motor turning
  initial begin
    seq_in = '0;
    ambient_meas = 16'h0000;
    motor_running = 1'b1;
    heavy_start = 1'b0;
  end
  // New operating point, set just after an edge
  task automatic apply(input logic [15:0] pos, neg, amb, input logic run, hvy);
    @(posedge hclk);
    seq_in <= '{pos_mag: pos, neg_mag: neg};
    ambient_meas <= amb;
    motor_running <= run;
    heavy_start <= hvy;
  endtask
endmodule
`default_nettype wire

//--- tb/tb_motor_thermal_replica.sv
`timescale 1ns/1ps
`default_nettype none
// Register-level checks at a short step period
module tb_motor_thermal_replica;
  import mtr_pkg::*;
  localparam int STEP = 200;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, motor_running, heavy_start, irq;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  mtr_seq_t seq_in;
  logic signed [15:0] ambient_meas, temperature;
  mtr_flags_t status;
  int err_count, compares;
  logic [31:0] exp_rst [12] = '{32'h1, 32'h64, 32'hA, 32'h64, 32'h19, 32'h50, 32'h64, 32'h3C,
    32'h64, 32'h64, 32'h19, 32'h0};
  mtr_thermal #(.STEP_CYCLES(STEP)) dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .seq_in, .ambient_meas, .motor_running,
    .heavy_start, .status, .temperature, .irq);
  mtr_upstream up_u (.hclk, .seq_in, .ambient_meas, .motor_running, .heavy_start);
  // One slave drives the bus ready
  assign hready = hreadyout;
  // 40 MHz clock
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic end_of_test();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  // Bounded wait for ready; a stuck bus ends the run
  task automatic rdy();
    int n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 64) begin
      @(posedge hclk);
      n++;
    end
    if (hreadyout !== 1'b1) begin
      err_count++;
      end_of_test();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] r;
    xfer(1'b1, a, v, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0, r);
  endtask
  // Two steps cover the wait and the calculation
  task automatic look(input logic [15:0] t, input logic [2:0] f);
    repeat (2 * STEP) @(posedge hclk);
    chk("temperature and flags", {t, f}, {temperature, status});
  endtask
  // Past any preload, the level change over one whole step
  task automatic drop(output logic [31:0] dl);
    logic [31:0] a, b;
    repeat (STEP) @(posedge hclk);
    rd(OFF_LEVEL, a);
    for (int n = 0; n < 2; n++) begin
      b = a;
      for (int k = 0; k < 200 && a === b; k++) rd(OFF_LEVEL, a);
      if (a === b) begin
        err_count++;
        end_of_test();
      end
    end
    dl = b - a;
  endtask
  initial begin
    err_count = 0;
    compares = 0;
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (12) @(posedge hclk);
    chk("outputs in reset", 32'h0, {irq, status, temperature});
    hresetn <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      rd(8'(4 * i), d);
      chk("reset value", exp_rst[i], d);
    end
    rd(OFF_INT_MASK, d);
    chk("mask reset", 32'h0, d);
    wr(8'h44, 32'hFFFFFFFF);
    rd(8'h44, d);
    chk("unmapped", 32'h0, d);
    $display("test reset values done");
    // Rated current holds a 100 percent preload steady
    up_u.apply(16'h03E8, 16'h0000, 16'h000A, 1'b1, 1'b0);
    wr(OFF_HEAT_TC, 32'h1);
    wr(OFF_STARTUP, 32'h64);
    wr(OFF_AMBIENT, 32'h1E);
    wr(OFF_CTRL, 32'h9);
    look(16'h0069, 3'h7);
    rd(OFF_LEVEL, d);
    chk("level", 32'h10000, d);
    rd(OFF_HEAT_CUR, d);
    chk("heat current", 32'h3E8, d);
    wr(OFF_CTRL, 32'h5);
    look(16'h0055, 3'h5);
    $display("test ambient and thresholds done");
    wr(OFF_NEG_WEIGHT, 32'h12C);
    up_u.apply(16'h03E8, 16'h03E8, 16'h000A, 1'b1, 1'b0);
    look(16'h0055, 3'h5);
    rd(OFF_HEAT_CUR, d);
    chk("weighted current", 32'h7D0, d);
    wr(OFF_NEG_WEIGHT, 32'h64);
    up_u.apply(16'h03E8, 16'h07D0, 16'h000A, 1'b1, 1'b0);
    repeat (2 * STEP) @(posedge hclk);
    rd(OFF_HEAT_CUR, d);
    chk("clamped current", 32'hDAC, d);
    $display("test heating current done");
    up_u.apply(16'h03E8, 16'h0000, 16'h001E, 1'b1, 1'b0);
    wr(OFF_CTRL, 32'hE);
    look(16'h0069, 3'h7);
    up_u.apply(16'h03E8, 16'h0000, 16'h0000, 1'b1, 1'b0);
    look(16'h004B, 3'h6);
    up_u.apply(16'h03E8, 16'h0000, 16'hFFEC, 1'b1, 1'b0);
    look(16'h0037, 3'h0);
    $display("test locked trip done");
    rd(OFF_INT_STAT, d);
    chk("event bits", 32'h7, d);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(OFF_INT_MASK, 32'h2);
    repeat (2) @(posedge hclk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(OFF_INT_STAT, 32'h7);
    rd(OFF_INT_STAT, d);
    chk("event clear", 32'h0, d);
    chk("irq cleared", 32'h0, {31'h0, irq});
    up_u.apply(16'h03E8, 16'h0000, 16'h001E, 1'b1, 1'b0);
    look(16'h0069, 3'h7);
    rd(OFF_INT_STAT, d);
    chk("rise events", 32'h3, d);
    chk("irq on trip rise", 32'h1, {31'h0, irq});
    wr(OFF_INT_MASK, 32'h4);
    repeat (2) @(posedge hclk);
    chk("irq other mask", 32'h0, {31'h0, irq});
    $display("test interrupts done");
    wr(OFF_CTRL, 32'h4);
    repeat (3) @(posedge hclk);
    chk("flags off", 32'h0, {29'h0, status});
    repeat (2 * STEP) @(posedge hclk);
    chk("flags stay off", 32'h0, {29'h0, status});
    $display("test mode off done");
    up_u.apply(16'h03E8, 16'h0000, 16'h001E, 1'b1, 1'b1);
    wr(OFF_CTRL, 32'hD);
    drop(d);
    chk("halved heat drop", 32'h1, 32'(d >= 32'h9 && d <= 32'hC));
    up_u.apply(16'h0000, 16'h0000, 16'h001E, 1'b1, 1'b0);
    wr(OFF_CTRL, 32'hD);
    drop(d);
    chk("heating drop", 32'h1, 32'(d >= 32'h14 && d <= 32'h17));
    wr(OFF_COOL_PCT, 32'h32);
    up_u.apply(16'h0000, 16'h0000, 16'h001E, 1'b0, 1'b0);
    wr(OFF_CTRL, 32'hD);
    drop(d);
    chk("cooling drop", 32'h1, 32'(d >= 32'h2A && d <= 32'h2D));
    $display("test time constants done");
    end_of_test();
  end
endmodule
`default_nettype wire
